// *** core/fdcc_config_regs.sv ***
/*
 * Floppy controller configuration registers behind an AXI4-Lite slave,
 * with the pin-side effects of the fields applied to the drive signals.
 * Assumes the controller core drives its requests on aclk and the
 * write-protect pin arrives asynchronously from the drive.
 */
`timescale 1ns/1ps
`include "fdcc_regs.svh"

module fdcc_config_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic active_drive,
    input wire logic [1:0] drive_sel_req,
    input wire logic [1:0] motor_req,
    input wire logic write_gate_req,
    input wire logic write_data_req,
    input wire logic density_req,
    input wire logic [1:0] rate_code,
    input wire logic write_protect_pin,
    output fdcc_pkg::fdcc_drive_pins_s drive_pins,
    output fdcc_pkg::fdcc_config_s cfg
);

    // ======================================================================
    // Register state
    logic [7:0] irq_sel_r, irq_sel_nxt;
    logic [7:0] dma_sel_r, dma_sel_nxt;
    logic [7:0] main_mode_r, main_mode_nxt;
    logic [7:0] sec_mode_r, sec_mode_nxt;
    logic [7:0] drv_type_r, drv_type_nxt;
    logic [7:0] drv_set_r [2];
    logic [7:0] drv_set_nxt [2];
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [2:0] wp_sync_r, wp_sync_nxt;
    logic wp_stable_r, wp_stable_nxt;
    fdcc_pkg::fdcc_drive_pins_s pins_r, pins_nxt;
    logic wr_take, rd_take;
    logic [7:0] wr_idx, rd_idx, wr_byte;
    logic wr_hit, rd_hit;
    logic [7:0] rd_val;
    logic [7:0] cur_set;
    logic [1:0] cur_type;
    logic sel_den;
    logic [11:0] rate_val;

    // ======================================================================
    // AXI4-Lite handshakes: write address and data are taken together
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = !rvalid_r;
    assign wr_take = s_axi_awready;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign wr_idx = s_axi_awaddr[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign wr_byte = s_axi_wdata[7:0];
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    // Decode: word aligned and nothing above index bits
    always_comb
    begin
        wr_hit = 1'b0;
        if (s_axi_awaddr[1:0] != 2'h0 || s_axi_awaddr[ADDR_W-1:10] != '0)
            wr_hit = 1'b0;
        else if (wr_idx == `FDCC_IDX_IRQ_SEL || wr_idx == `FDCC_IDX_DMA_SEL)
            wr_hit = 1'b1;
        else if (wr_idx == `FDCC_IDX_MAIN_MODE || wr_idx == `FDCC_IDX_SEC_MODE)
            wr_hit = 1'b1;
        else if (wr_idx == `FDCC_IDX_DRV_TYPE || wr_idx == `FDCC_IDX_DRV0_SET)
            wr_hit = 1'b1;
        else if (wr_idx == `FDCC_IDX_DRV1_SET)
            wr_hit = 1'b1;
    end

    // Read mux; reserved bits were masked on write so they read zero
    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[ADDR_W-1:10] != '0)
            rd_hit = 1'b0;
        else if (rd_idx == `FDCC_IDX_IRQ_SEL)
            rd_val = irq_sel_r;
        else if (rd_idx == `FDCC_IDX_DMA_SEL)
            rd_val = dma_sel_r;
        else if (rd_idx == `FDCC_IDX_MAIN_MODE)
            rd_val = main_mode_r;
        else if (rd_idx == `FDCC_IDX_SEC_MODE)
            rd_val = sec_mode_r;
        else if (rd_idx == `FDCC_IDX_DRV_TYPE)
            rd_val = drv_type_r;
        else if (rd_idx == `FDCC_IDX_DRV0_SET)
            rd_val = drv_set_r[0];
        else if (rd_idx == `FDCC_IDX_DRV1_SET)
            rd_val = drv_set_r[1];
        else
            rd_hit = 1'b0;
    end

    // Register writes land only when byte lane 0 is strobed
    always_comb
    begin
        irq_sel_nxt = irq_sel_r;
        dma_sel_nxt = dma_sel_r;
        main_mode_nxt = main_mode_r;
        sec_mode_nxt = sec_mode_r;
        drv_type_nxt = drv_type_r;
        drv_set_nxt[0] = drv_set_r[0];
        drv_set_nxt[1] = drv_set_r[1];
        // Refused (SLVERR) addresses must not store, even if the index bits match
        if (wr_take && s_axi_wstrb[0] && wr_hit)
        begin
            if (wr_idx == `FDCC_IDX_IRQ_SEL)
                irq_sel_nxt = wr_byte & `FDCC_MSK_IRQ_SEL;
            else if (wr_idx == `FDCC_IDX_DMA_SEL)
                dma_sel_nxt = wr_byte & `FDCC_MSK_DMA_SEL;
            else if (wr_idx == `FDCC_IDX_MAIN_MODE)
                main_mode_nxt = wr_byte;
            else if (wr_idx == `FDCC_IDX_SEC_MODE)
                sec_mode_nxt = wr_byte;
            else if (wr_idx == `FDCC_IDX_DRV_TYPE)
                drv_type_nxt = wr_byte;
            else if (wr_idx == `FDCC_IDX_DRV0_SET)
                drv_set_nxt[0] = wr_byte & `FDCC_MSK_DRV_SET;
            else if (wr_idx == `FDCC_IDX_DRV1_SET)
                drv_set_nxt[1] = wr_byte & `FDCC_MSK_DRV_SET;
        end
    end

    // Responses: one outstanding write and one outstanding read
    always_comb
    begin
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (wr_take)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? `FDCC_RESP_OKAY : `FDCC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_nxt = 1'b0;
        if (rd_take)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = rd_hit ? `FDCC_RESP_OKAY : `FDCC_RESP_SLVERR;
            rdata_nxt = {24'h000000, rd_val};
        end
        else if (s_axi_rready)
            rvalid_nxt = 1'b0;
    end

    // ======================================================================
    // Write-protect pin: three stages, a change counts once 2nd and 3rd agree
    always_comb
    begin
        wp_sync_nxt = {wp_sync_r[1:0], write_protect_pin};
        wp_stable_nxt = wp_stable_r;
        if (wp_sync_r[1] == wp_sync_r[2])
            wp_stable_nxt = wp_sync_r[2];
    end

    // ======================================================================
    // Data-rate tables and density-select pins for the active drive
    assign cur_set = drv_set_r[active_drive];
    assign cur_type = cur_set[`FDCC_DS_TYPE_HI:`FDCC_DS_TYPE_LO];

    // Reserved table code falls back to the regular mapping
    // Density select is high for codes 11 and 00 in every table
    always_comb
    begin
        sel_den = (rate_code[1] == rate_code[0]);
        rate_val = `FDCC_RATE_500K;
        case (rate_code)
            2'h3: rate_val = `FDCC_RATE_1M;
            2'h0: rate_val = `FDCC_RATE_500K;
            2'h1: rate_val = `FDCC_RATE_300K;
            default: rate_val = `FDCC_RATE_250K;
        endcase
        if (rate_code == 2'h1)
        begin
            case (fdcc_pkg::fdcc_ratetbl_e'(cur_set[`FDCC_DS_TABLE_HI:`FDCC_DS_TABLE_LO]))
                fdcc_pkg::FDCC_TBL_THREE_MODE: rate_val = `FDCC_RATE_500K;
                fdcc_pkg::FDCC_TBL_TAPE_2M: rate_val = `FDCC_RATE_2M;
                default: rate_val = `FDCC_RATE_300K;
            endcase
        end
    end

    // Drive pins: swap, polarity, then overrides that must win
    always_comb
    begin
        logic inv;
        logic [1:0] dsel, mot;
        inv = !main_mode_r[`FDCC_MM_POLARITY];
        dsel = drive_sel_req;
        mot = motor_req;
        if (main_mode_r[`FDCC_MM_SWAP])
        begin
            dsel = {drive_sel_req[0], drive_sel_req[1]};
            mot = {motor_req[0], motor_req[1]};
        end
        pins_nxt.drive_sel = dsel ^ {2{inv}};
        pins_nxt.motor_on = mot ^ {2{inv}};
        pins_nxt.write_gate = write_gate_req ^ inv;
        pins_nxt.write_data_pin = write_data_req ^ inv;
        if (sec_mode_r[`FDCC_SM_WR_INHIBIT])
        begin
            pins_nxt.write_gate = 1'b1;
            pins_nxt.write_data_pin = 1'b1;
        end
        case (sec_mode_r[`FDCC_SM_DENS_HI:`FDCC_SM_DENS_LO])
            2'h2: pins_nxt.density = 1'b1;
            2'h3: pins_nxt.density = 1'b0;
            default: pins_nxt.density = density_req ^ inv;
        endcase
        case (cur_type)
            2'h0: pins_nxt.dens_sel = {rate_code[0], sel_den};
            2'h1: pins_nxt.dens_sel = {rate_code[0], rate_code[1]};
            2'h2: pins_nxt.dens_sel = {rate_code[0], sel_den};
            default: pins_nxt.dens_sel = {rate_code[1], rate_code[0]};
        endcase
    end

    // ======================================================================
    // All state registers; reset takes constants only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_sel_r <= `FDCC_RST_IRQ_SEL;
            dma_sel_r <= `FDCC_RST_DMA_SEL;
            main_mode_r <= `FDCC_RST_MAIN_MODE;
            sec_mode_r <= `FDCC_RST_SEC_MODE;
            drv_type_r <= `FDCC_RST_DRV_TYPE;
            drv_set_r[0] <= `FDCC_RST_DRV_SET;
            drv_set_r[1] <= `FDCC_RST_DRV_SET;
            bvalid_r <= 1'b0;
            bresp_r <= `FDCC_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= `FDCC_RESP_OKAY;
            rdata_r <= 32'h00000000;
            wp_sync_r <= 3'h0;
            wp_stable_r <= 1'b0;
            pins_r <= '1; // Inactive for the active-low reset polarity
        end
        else
        begin
            irq_sel_r <= irq_sel_nxt;
            dma_sel_r <= dma_sel_nxt;
            main_mode_r <= main_mode_nxt;
            sec_mode_r <= sec_mode_nxt;
            drv_type_r <= drv_type_nxt;
            drv_set_r[0] <= drv_set_nxt[0];
            drv_set_r[1] <= drv_set_nxt[1];
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            wp_sync_r <= wp_sync_nxt;
            wp_stable_r <= wp_stable_nxt;
            pins_r <= pins_nxt;
        end
    end

    // ======================================================================
    // Decoded configuration outputs, straight from register bits except the rate, which also decodes rate_code, and write protect, which also takes the pin
    assign drive_pins = pins_r;
    assign cfg.irq_line = irq_sel_r[3:0];
    assign cfg.dma_channel = dma_sel_r[1:0];
    assign cfg.dma_enable = !dma_sel_r[2];
    assign cfg.pullup_off = main_mode_r[`FDCC_MM_PULLUP_OFF];
    assign cfg.non_burst = main_mode_r[`FDCC_MM_NON_BURST];
    assign cfg.three_mode = main_mode_r[`FDCC_MM_THREE_MODE];
    assign cfg.if_mode = fdcc_pkg::fdcc_ifmode_e'(main_mode_r[`FDCC_MM_IFMODE_HI:`FDCC_MM_IFMODE_LO]);
    assign cfg.boot_drive = sec_mode_r[`FDCC_SM_BOOT_HI:`FDCC_SM_BOOT_LO];
    assign cfg.drive_types = drv_type_r;
    assign cfg.precomp_en = !cur_set[`FDCC_DS_PRECOMP_OFF];
    assign cfg.rate_kbps = rate_val;
    assign cfg.write_protected = sec_mode_r[`FDCC_SM_FORCE_WP] || wp_stable_r;
    // Second-drive flag only shows in the PS/2 status layout
    assign cfg.second_drive_sra = (cfg.if_mode == fdcc_pkg::FDCC_IF_PS2)
        && !main_mode_r[`FDCC_MM_NO_SECOND];
    assign cfg.tape_media_id = sec_mode_r[`FDCC_SM_MEDIA_HI:`FDCC_SM_MEDIA_LO];

    // ======================================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_irq_write;
        wr_take && s_axi_wstrb[0] && wr_hit && wr_idx == `FDCC_IDX_IRQ_SEL;
    endsequence

    a_irq_field_stored: assert property (s_irq_write
        |=> cfg.irq_line == $past(s_axi_wdata[3:0]) && irq_sel_r[7:4] == 4'h0)
        else $error("irq select field not stored");
    a_pullup_follows_bit: assert property (wr_take && s_axi_wstrb[0] && wr_hit
        && wr_idx == `FDCC_IDX_MAIN_MODE |=> cfg.pullup_off == $past(s_axi_wdata[7]))
        else $error("pull-up control wrong");
    a_inhibit_holds_high: assert property (sec_mode_r[1] |=> pins_r.write_gate && pins_r.write_data_pin)
        else $error("write inhibit not holding pins high");
    a_swap_drive_sel: assert property (main_mode_r[4] && main_mode_r[6] && $stable(main_mode_r)
        |=> pins_r.drive_sel == {$past(drive_sel_req[0]), $past(drive_sel_req[1])})
        else $error("drive select swap wrong");
    a_density_forced: assert property (sec_mode_r[3:2] == 2'h2 && $stable(sec_mode_r)
        |=> pins_r.density == 1'b1)
        else $error("density not forced high");
    a_force_wp: assert property (sec_mode_r[0] |-> cfg.write_protected)
        else $error("forced write protect ignored");
    a_dma_disable: assert property (dma_sel_r[2] |-> !cfg.dma_enable)
        else $error("dma not disabled");
    a_tape_2m_rate: assert property (cur_set[4:3] == 2'h2 && rate_code == 2'h1
        |-> rate_val == `FDCC_RATE_2M)
        else $error("2M tape rate wrong");
    a_wp_pin_latency: assert property ($rose(write_protect_pin) ##1 write_protect_pin [*3]
        |-> ##1 wp_stable_r)
        else $error("write protect pin not followed");
    a_media_id_tape: assert property (wr_take && s_axi_wstrb[0] && wr_hit
        && wr_idx == `FDCC_IDX_SEC_MODE |=> cfg.tape_media_id == $past(s_axi_wdata[5:4]))
        else $error("media id not reflected");
    a_bresp_one_cycle: assert property (wr_take |=> s_axi_bvalid)
        else $error("write response missing");

endmodule

// *** core/fdcc_pkg.sv ***
/*
 * Types for the floppy controller configuration register bank.
 * Assumes the constants header is on the include path.
 */
package fdcc_pkg;

    // ======================================================================
    // Mode enumerations
    typedef enum logic [1:0] {
        FDCC_IF_MODEL30 = 2'h0,
        FDCC_IF_PS2 = 2'h1,
        FDCC_IF_RSVD = 2'h2,
        FDCC_IF_AT = 2'h3
    } fdcc_ifmode_e;

    typedef enum logic [1:0] {
        FDCC_TBL_REGULAR = 2'h0,
        FDCC_TBL_THREE_MODE = 2'h1,
        FDCC_TBL_TAPE_2M = 2'h2,
        FDCC_TBL_RSVD = 2'h3
    } fdcc_ratetbl_e;

    // ======================================================================
    // Drive-side pin group, already in pin polarity
    typedef struct packed {
        logic [1:0] drive_sel;
        logic [1:0] motor_on;
        logic write_gate;
        logic write_data_pin;
        logic density;
        logic [1:0] dens_sel;
    } fdcc_drive_pins_s;

    // Decoded configuration seen by the controller core
    typedef struct packed {
        logic [3:0] irq_line;
        logic [1:0] dma_channel;
        logic dma_enable;
        logic pullup_off;
        logic non_burst;
        logic three_mode;
        fdcc_ifmode_e if_mode;
        logic [1:0] boot_drive;
        logic [7:0] drive_types;
        logic precomp_en;
        logic [11:0] rate_kbps;
        logic write_protected;
        logic second_drive_sra;
        logic [1:0] tape_media_id;
    } fdcc_config_s;

endpackage

// *** core/fdcc_regs.svh ***
/*
 * Offsets, field positions, reset values and bus codes for the floppy
 * controller configuration register bank.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef FDCC_REGS_SVH
`define FDCC_REGS_SVH

// ==========================================================================
// Register indices; byte address is four times the index
`define FDCC_IDX_IRQ_SEL 8'h70
`define FDCC_IDX_DMA_SEL 8'h74
`define FDCC_IDX_MAIN_MODE 8'hf0
`define FDCC_IDX_SEC_MODE 8'hf1
`define FDCC_IDX_DRV_TYPE 8'hf2
`define FDCC_IDX_DRV0_SET 8'hf4
`define FDCC_IDX_DRV1_SET 8'hf5

// ==========================================================================
// Reset values
`define FDCC_RST_IRQ_SEL 8'h06
`define FDCC_RST_DMA_SEL 8'h02
`define FDCC_RST_MAIN_MODE 8'h8e
`define FDCC_RST_SEC_MODE 8'h00
`define FDCC_RST_DRV_TYPE 8'hff
`define FDCC_RST_DRV_SET 8'h00

// ==========================================================================
// Writable bit masks; reserved bits read as zero
`define FDCC_MSK_IRQ_SEL 8'h0f
`define FDCC_MSK_DMA_SEL 8'h07
`define FDCC_MSK_DRV_SET 8'h5b

// ==========================================================================
// Field positions
`define FDCC_MM_PULLUP_OFF 7
`define FDCC_MM_POLARITY 6
`define FDCC_MM_NO_SECOND 5
`define FDCC_MM_SWAP 4
`define FDCC_MM_IFMODE_HI 3
`define FDCC_MM_IFMODE_LO 2
`define FDCC_MM_NON_BURST 1
`define FDCC_MM_THREE_MODE 0
`define FDCC_SM_BOOT_HI 7
`define FDCC_SM_BOOT_LO 6
`define FDCC_SM_MEDIA_HI 5
`define FDCC_SM_MEDIA_LO 4
`define FDCC_SM_DENS_HI 3
`define FDCC_SM_DENS_LO 2
`define FDCC_SM_WR_INHIBIT 1
`define FDCC_SM_FORCE_WP 0
`define FDCC_DS_PRECOMP_OFF 6
`define FDCC_DS_TABLE_HI 4
`define FDCC_DS_TABLE_LO 3
`define FDCC_DS_TYPE_HI 1
`define FDCC_DS_TYPE_LO 0

// ==========================================================================
// Bus responses and data rates in kbit/s (MFM)
`define FDCC_RESP_OKAY 2'h0
`define FDCC_RESP_SLVERR 2'h2
`define FDCC_RATE_250K 12'h0fa
`define FDCC_RATE_300K 12'h12c
`define FDCC_RATE_500K 12'h1f4
`define FDCC_RATE_1M 12'h3e8
`define FDCC_RATE_2M 12'h7d0

`endif

// *** verif/fdcc_drive_model.sv ***
/*
 * Drive-side model: the write-protect tab of the media in the drive.
 * Assumes the bench decides whether the inserted media is protected.
 */
`timescale 1ns/1ps

// ==========================================================================
// Drive write-protect sensor
module fdcc_drive_model (
    input wire logic aclk,
    input wire logic media_wp,
    output logic write_protect_pin
);
    // Sensor moves on the falling edge, away from the sampling edge, so the synchroniser sees a loose change
    always_ff @(negedge aclk)
    begin
        write_protect_pin <= media_wp;
    end
endmodule

// *** verif/tb_top.sv ***
/*
 * Self-checking bench for the floppy controller configuration registers.
 * Assumes the design, its package and the constants header are compiled first.
 */
`timescale 1ns/1ps
`include "fdcc_regs.svh"

module tb_top;
    typedef struct {logic [7:0] idx; logic [7:0] rst; logic [7:0] wr; logic [7:0] rd;} fdcc_row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, wp_pin;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic act = 1'b0, wg = 1'b0, wd = 1'b0, dens = 1'b0, media_wp = 1'b0;
    logic [1:0] dsel = 2'h0, mot = 2'h0, rcode = 2'h0;
    logic [3:0] wstrb = 4'h1;
    fdcc_pkg::fdcc_drive_pins_s pins;
    fdcc_pkg::fdcc_config_s cfg;
    int err_count = 0;
    int cmp_count = 0;
    fdcc_row_s rows [7] = '{'{8'h70, 8'h06, 8'hff, 8'h0f}, '{8'h74, 8'h02, 8'hff, 8'h07},
        '{8'hf0, 8'h8e, 8'h4d, 8'h4d}, '{8'hf1, 8'h00, 8'h30, 8'h30}, '{8'hf2, 8'hff, 8'h1b, 8'h1b},
        '{8'hf4, 8'h00, 8'hff, 8'h5b}, '{8'hf5, 8'h00, 8'ha4, 8'h00}};
    logic [11:0] rates [6] = '{`FDCC_RATE_1M, `FDCC_RATE_500K, `FDCC_RATE_300K, `FDCC_RATE_250K,
        `FDCC_RATE_500K, `FDCC_RATE_2M};
    logic [3:0] rsel [6] = '{4'h3, 4'h0, 4'h1, 4'h2, 4'h5, 4'h9};

    fdcc_config_regs u_fdcc_config_regs (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .active_drive(act), .drive_sel_req(dsel), .motor_req(mot),
        .write_gate_req(wg), .write_data_req(wd), .density_req(dens), .rate_code(rcode),
        .write_protect_pin(wp_pin), .drive_pins(pins), .cfg(cfg));
    fdcc_drive_model u_fdcc_drive_model (.aclk(aclk), .media_wp(media_wp), .write_protect_pin(wp_pin));

    // ======================================================================
    // Clock and watchdog; the full run needs well under 3000 cycles
    always #50 aclk = ~aclk;

    initial
    begin
        #(3000 * 100);
        err_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        close_out();
    end

    // ======================================================================
    // Bus and comparison helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Both channels offered together; the slave takes them on the same edge
    task automatic wr8(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (!(awready && wready) && ++n < 50);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid && ++n < 50);
        r = bresp;
        bready <= 1'b0;
        chk(n < 50, 1, "write handshake");
    endtask

    task automatic rd8(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready && ++n < 50);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid && ++n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        chk(n < 50, 1, "read handshake");
    endtask

    // Write that must be accepted, then let registered pins follow
    task automatic wset(input logic [7:0] idx, input logic [7:0] d);
        wr8(idx, d, resp);
        chk(resp, `FDCC_RESP_OKAY, "write response");
        repeat (3) @(posedge aclk);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset value, masked write and readback of every register
        foreach (rows[i])
        begin
            rd8(rows[i].idx, rd, resp);
            chk(rd, {24'h0, rows[i].rst}, "reset value");
            wset(rows[i].idx, rows[i].wr);
            rd8(rows[i].idx, rd, resp);
            chk(rd, {24'h0, rows[i].rd}, "readback");
        end
        chk({cfg.irq_line, cfg.dma_enable, cfg.drive_types, cfg.tape_media_id}, 15'h786f, "fields");
        chk({cfg.pullup_off, cfg.non_burst, cfg.three_mode, cfg.second_drive_sra, cfg.if_mode}, 6'h0b, "main");
        chk({cfg.precomp_en, cfg.boot_drive}, 3'h0, "precomp off, boot A");
        $display("test table done");
        // Second drive report only in PS/2 mode, DMA channel one
        wset(8'hf0, 8'h05);
        wset(8'h74, 8'h01);
        chk({cfg.second_drive_sra, cfg.if_mode, cfg.dma_enable, cfg.dma_channel}, 6'h2d, "ps2 dma1");
        // Unmapped index refused on both channels
        wr8(8'hf3, 8'h55, resp);
        chk(resp, `FDCC_RESP_SLVERR, "unmapped write");
        rd8(8'hf3, rd, resp);
        chk(rd, 32'h0, "unmapped read data");
        chk(resp, `FDCC_RESP_SLVERR, "unmapped read");
        // Write with byte lane 0 unstrobed is answered but stores nothing
        wstrb <= 4'h0;
        wr8(8'h70, 8'h03, resp);
        wstrb <= 4'h1;
        chk(resp, `FDCC_RESP_OKAY, "unstrobed write");
        rd8(8'h70, rd, resp);
        chk(rd, 32'h0f, "unstrobed kept");
        $display("test bus done");
        // Swap with both polarities
        dsel <= 2'b01;
        mot <= 2'b10;
        wset(8'hf0, 8'h50);
        chk({pins.drive_sel, pins.motor_on}, 4'b1001, "swap high");
        wset(8'hf0, 8'h10);
        chk({pins.drive_sel, pins.motor_on}, 4'b0110, "swap low");
        // Write inhibit on active-high pins
        wset(8'hf0, 8'h40);
        wset(8'hf1, 8'h02);
        chk({pins.write_gate, pins.write_data_pin}, 2'b11, "inhibit");
        wset(8'hf1, 8'h00);
        chk({pins.write_gate, pins.write_data_pin}, 2'b00, "no inhibit");
        // Density forcing over every code and both request levels
        for (int k = 0; k < 8; k++)
        begin
            dens <= k[2];
            wset(8'hf1, {4'h0, k[1:0], 2'b00});
            chk(pins.density, (k[1:0] == 2'd2) ? 1'b1 : (k[1:0] == 2'd3) ? 1'b0 : k[2], "density");
        end
        $display("test pins done");
        // Rate tables on the first drive
        foreach (rates[i])
        begin
            rcode <= rsel[i][1:0];
            wset(8'hf4, {3'h0, rsel[i][3:2], 3'h0});
            chk(cfg.rate_kbps, rates[i], "rate");
        end
        // Second drive settings and density select pins
        act <= 1'b1;
        rcode <= 2'b01;
        wset(8'hf5, 8'h13);
        chk({cfg.rate_kbps, pins.dens_sel}, {`FDCC_RATE_2M, 2'b01}, "drive1 type3");
        wset(8'hf5, 8'h51);
        chk({cfg.precomp_en, pins.dens_sel}, 3'b010, "drive1 type1");
        // Density select term on the types that use it
        rcode <= 2'b11;
        wset(8'hf5, 8'h00);
        chk(pins.dens_sel, 2'b11, "type0 code3");
        rcode <= 2'b01;
        wset(8'hf5, 8'h02);
        chk(pins.dens_sel, 2'b10, "type2 code1");
        $display("test rates done");
        // Write protect from the pin and forced
        media_wp <= 1'b1;
        repeat (8) @(posedge aclk);
        chk(cfg.write_protected, 1'b1, "pin protect");
        media_wp <= 1'b0;
        repeat (8) @(posedge aclk);
        chk(cfg.write_protected, 1'b0, "pin clear");
        wset(8'hf1, 8'h01);
        chk(cfg.write_protected, 1'b1, "forced");
        $display("test protect done");
        // Reset in mid-run restores defaults
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(pins, 9'h1ff, "pins in reset");
        aresetn <= 1'b1;
        rd8(8'hf0, rd, resp);
        chk(rd, 32'h8e, "main after reset");
        $display("test reset done");
        close_out();
    end
endmodule
